// File: shared/clocfg_regs.vh
// Register offsets, field positions, reset values and codes of the clock and offset config bank
`ifndef CLOCFG_REGS_VH
`define CLOCFG_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CLOCFG_ADDR_W 5
`define CLOCFG_OFS_DELAY_LOOP_RESTART_CTRL 5'h08
`define CLOCFG_OFS_CLOCK_MULTIPLIER_DIVIDER 5'h09
`define CLOCFG_OFS_DELAY_LOOP_TUNING 5'h0A
`define CLOCFG_OFS_CLOCK_LOOP_TUNING 5'h0B
`define CLOCFG_OFS_OFFSET_STROBE_CHAN_A_HIGH 5'h0C
`define CLOCFG_OFS_CHAN_A_OFFSET_LOW 5'h0D
`define CLOCFG_OFS_OUT_SELECT_CHAN_B_HIGH 5'h0E
`define CLOCFG_OFS_CHAN_B_OFFSET_LOW 5'h0F

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CLOCFG_RST_BYTE 8'h00
`define CLOCFG_RST_OFFSET 13'h0000

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CLOCFG_RESTART_BIT 2
`define CLOCFG_MULT_MSB 7
`define CLOCFG_MULT_LSB 3
`define CLOCFG_REFDIV_MSB 2
`define CLOCFG_REFDIV_LSB 0
`define CLOCFG_TRIM_MSB 7
`define CLOCFG_TRIM_LSB 4
`define CLOCFG_INVCLK_BIT 3
`define CLOCFG_BIAS_MSB 2
`define CLOCFG_BIAS_LSB 0
`define CLOCFG_CLAMP_BIT 7
`define CLOCFG_HALVING_BIT 6
`define CLOCFG_GAIN_MSB 5
`define CLOCFG_GAIN_LSB 4
`define CLOCFG_RANGE_MSB 3
`define CLOCFG_RANGE_LSB 0
`define CLOCFG_STROBE_BIT 5
`define CLOCFG_OFSHI_MSB 4
`define CLOCFG_OFSHI_LSB 0
`define CLOCFG_SRCSEL_MSB 7
`define CLOCFG_SRCSEL_LSB 5

// ----------------------------------------
// Codes
// ----------------------------------------
`define CLOCFG_SRC_PHASE_LOCK 3'h1
`define CLOCFG_SRC_DELAY_LOCK 3'h2
`define CLOCFG_SRC_PATTERN_ERR 3'h3
`define CLOCFG_SRC_BUFFER_ERR 3'h4
`define CLOCFG_SRC_SELF_CHECK 3'h5
`define CLOCFG_TRIM_DEFAULT 4'h8
`define CLOCFG_BIAS_FORBIDDEN 3'h4
`define CLOCFG_DELAY_MID 8'h80

`endif

// File: rtl/clocfg_offset_stage.v
// Double-buffered two-channel offset staging with load strobe edge detect
`timescale 1ns/1ps
`include "clocfg_regs.vh"

module clocfg_offset_stage (
  input wire sys_clk,
  input wire reset_n,
  input wire load_strobe,
  input wire [12:0] staged_a,
  input wire [12:0] staged_b,
  output reg [12:0] work_a,
  output reg [12:0] work_b,
  output reg load_pulse
);

  reg strobe_prev;

  // ----------------------------------------
  // Strobe edge and working copy
  // ----------------------------------------
  always @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      strobe_prev <= 1'b0;
      work_a <= `CLOCFG_RST_OFFSET;
      work_b <= `CLOCFG_RST_OFFSET;
      load_pulse <= 1'b0;
    end
    else
    begin
      strobe_prev <= load_strobe;
      load_pulse <= load_strobe & ~strobe_prev;
      if (load_strobe && !strobe_prev)
      begin
        work_a <= staged_a;
        work_b <= staged_b;
      end
    end
  end

endmodule // clocfg_offset_stage

// File: rtl/clocfg_regs_top.v
// Clock-loop, offset and serial-output-select register bank
`timescale 1ns/1ps
`include "clocfg_regs.vh"

// Functional notes
// - Restart bit set: delay filter cleared, delay line held mid-range.
// - Restart bit cleared: delay loop acquires lock to data clock.
// - Restart bit set forces delay loop lock status to zero.
// - Multiplier field thermometer decode 1..32; other codes invalid.
// - Reference divider thermometer decode 1..8; other codes invalid.
// - Four-bit delay trim, 50 to 125 degrees, 90 is default; reset here loads trim code 0, not CLOCFG_TRIM_DEFAULT.
// - Invert bit inverts internal delay loop clock.
// - Clamp bit holds phase loop filter at zero; host toggles it.
// - Halving bit halves the loop output clock.
// - Oscillator range code 0000 lowest, 1111 highest.
// - Strobe rising edge copies both staged offsets to working offsets.
// - Strobe never self-clears; host clears before new staged values.
// - Channel A staged offset high at 0x0C bits 4:0, low at 0x0D.
// - Channel B staged offset high at 0x0E bits 4:0, low at 0x0F.
// - Source select drives serial output from chosen status indicator.
// - In four-wire mode a status selection overrides serial read data.
// - Offset enable adds working offsets into channel data paths.
// - Four-wire select picks four-pin serial mode, else three-pin.
module clocfg_regs_top (
  input wire sys_clk,
  input wire reset_n,
  input wire reg_wr,
  input wire reg_rd,
  input wire [4:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  output reg reg_rvalid,
  input wire four_wire_serial_sel,
  input wire offset_enable,
  input wire serial_read_bit,
  input wire serial_read_active,
  input wire phase_loop_lock,
  input wire delay_loop_lock_raw,
  input wire pattern_err,
  input wire buffer_err,
  input wire self_check_fail_flag,
  input wire [15:0] chan_a_data_in,
  input wire [15:0] chan_b_data_in,
  output reg [15:0] chan_a_data_out,
  output reg [15:0] chan_b_data_out,
  output reg serial_data_out,
  output reg serial_data_out_en_n,
  output reg delay_filter_zero,
  output reg [7:0] delay_line_ctrl,
  output reg delay_loop_acquire,
  output reg delay_loop_locked,
  output reg [3:0] delay_trim,
  output reg delay_clk_invert,
  output reg [2:0] delay_bias,
  output reg delay_bias_forbidden,
  output reg [5:0] feedback_mult,
  output reg [3:0] ref_div,
  output reg div_code_invalid,
  output reg loop_filter_clamp,
  output reg osc_halving,
  output reg [1:0] osc_gain,
  output reg [3:0] osc_range,
  output reg offset_loaded
);

  // ----------------------------------------
  // Decode functions
  // ----------------------------------------
  function [5:0] mult_decode;
    input [4:0] code;
    begin
      case (code)
        5'h00: mult_decode = 6'h01;
        5'h01: mult_decode = 6'h02;
        5'h03: mult_decode = 6'h04;
        5'h07: mult_decode = 6'h08;
        5'h0F: mult_decode = 6'h10;
        5'h1F: mult_decode = 6'h20;
        default: mult_decode = 6'h00;
      endcase
    end
  endfunction

  function [3:0] div_decode;
    input [2:0] code;
    begin
      case (code)
        3'h0: div_decode = 4'h1;
        3'h1: div_decode = 4'h2;
        3'h3: div_decode = 4'h4;
        3'h7: div_decode = 4'h8;
        default: div_decode = 4'h0;
      endcase
    end
  endfunction

  function status_bit_sel;
    input [2:0] sel;
    begin
      status_bit_sel = (sel >= `CLOCFG_SRC_PHASE_LOCK) && (sel <= `CLOCFG_SRC_SELF_CHECK);
    end
  endfunction

  // Sign-extends a 13-bit offset and adds it to a 16-bit sample
  function [15:0] add_offset;
    input [15:0] sample;
    input [12:0] ofs;
    begin
      add_offset = sample + {{3{ofs[12]}}, ofs};
    end
  endfunction

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  reg [7:0] restart_ctrl;
  reg [7:0] mult_div;
  reg [7:0] delay_tuning;
  reg [7:0] loop_tuning;
  reg [7:0] strobe_a_high;
  reg [7:0] a_low;
  reg [7:0] sel_b_high;
  reg [7:0] b_low;
  reg [7:0] next_rdata;
  reg next_sdo;
  reg next_sdo_en_n;
  reg status_bit;
  wire [12:0] staged_a;
  wire [12:0] staged_b;
  wire [12:0] work_a;
  wire [12:0] work_b;
  wire load_pulse;
  wire [2:0] src_sel;
  wire restart;

  assign staged_a = {strobe_a_high[`CLOCFG_OFSHI_MSB:`CLOCFG_OFSHI_LSB], a_low};
  assign staged_b = {sel_b_high[`CLOCFG_OFSHI_MSB:`CLOCFG_OFSHI_LSB], b_low};
  assign src_sel = sel_b_high[`CLOCFG_SRCSEL_MSB:`CLOCFG_SRCSEL_LSB];
  assign restart = restart_ctrl[`CLOCFG_RESTART_BIT];

  // Reserved bits are stored as written so software reads back what it wrote
  always @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      restart_ctrl <= `CLOCFG_RST_BYTE;
      mult_div <= `CLOCFG_RST_BYTE;
      delay_tuning <= `CLOCFG_RST_BYTE;
      loop_tuning <= `CLOCFG_RST_BYTE;
      strobe_a_high <= `CLOCFG_RST_BYTE;
      a_low <= `CLOCFG_RST_BYTE;
      sel_b_high <= `CLOCFG_RST_BYTE;
      b_low <= `CLOCFG_RST_BYTE;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `CLOCFG_OFS_DELAY_LOOP_RESTART_CTRL)
        restart_ctrl <= reg_wdata;
      else if (reg_addr == `CLOCFG_OFS_CLOCK_MULTIPLIER_DIVIDER)
        mult_div <= reg_wdata;
      else if (reg_addr == `CLOCFG_OFS_DELAY_LOOP_TUNING)
        delay_tuning <= reg_wdata;
      else if (reg_addr == `CLOCFG_OFS_CLOCK_LOOP_TUNING)
        loop_tuning <= reg_wdata;
      else if (reg_addr == `CLOCFG_OFS_OFFSET_STROBE_CHAN_A_HIGH)
        strobe_a_high <= reg_wdata;
      else if (reg_addr == `CLOCFG_OFS_CHAN_A_OFFSET_LOW)
        a_low <= reg_wdata;
      else if (reg_addr == `CLOCFG_OFS_OUT_SELECT_CHAN_B_HIGH)
        sel_b_high <= reg_wdata;
      else if (reg_addr == `CLOCFG_OFS_CHAN_B_OFFSET_LOW)
        b_low <= reg_wdata;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always @*
  begin
    next_rdata = 8'h00;
    if (reg_addr == `CLOCFG_OFS_DELAY_LOOP_RESTART_CTRL)
      next_rdata = restart_ctrl;
    else if (reg_addr == `CLOCFG_OFS_CLOCK_MULTIPLIER_DIVIDER)
      next_rdata = mult_div;
    else if (reg_addr == `CLOCFG_OFS_DELAY_LOOP_TUNING)
      next_rdata = delay_tuning;
    else if (reg_addr == `CLOCFG_OFS_CLOCK_LOOP_TUNING)
      next_rdata = loop_tuning;
    else if (reg_addr == `CLOCFG_OFS_OFFSET_STROBE_CHAN_A_HIGH)
      next_rdata = strobe_a_high;
    else if (reg_addr == `CLOCFG_OFS_CHAN_A_OFFSET_LOW)
      next_rdata = a_low;
    else if (reg_addr == `CLOCFG_OFS_OUT_SELECT_CHAN_B_HIGH)
      next_rdata = sel_b_high;
    else if (reg_addr == `CLOCFG_OFS_CHAN_B_OFFSET_LOW)
      next_rdata = b_low;
  end

  always @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // Offset staging
  // ----------------------------------------
  clocfg_offset_stage u_offset_stage (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .load_strobe(strobe_a_high[`CLOCFG_STROBE_BIT]),
    .staged_a(staged_a),
    .staged_b(staged_b),
    .work_a(work_a),
    .work_b(work_b),
    .load_pulse(load_pulse)
  );

  // ----------------------------------------
  // Serial output source
  // ----------------------------------------
  always @*
  begin
    case (src_sel)
      `CLOCFG_SRC_PHASE_LOCK: status_bit = phase_loop_lock;
      `CLOCFG_SRC_DELAY_LOCK: status_bit = delay_loop_lock_raw & ~restart;
      `CLOCFG_SRC_PATTERN_ERR: status_bit = pattern_err;
      `CLOCFG_SRC_BUFFER_ERR: status_bit = buffer_err;
      `CLOCFG_SRC_SELF_CHECK: status_bit = self_check_fail_flag;
      default: status_bit = 1'b0;
    endcase
    next_sdo = serial_read_bit;
    next_sdo_en_n = 1'b1;
    if (status_bit_sel(src_sel))
    begin
      // Status wins in both modes; in four-wire it overrides read data
      next_sdo = status_bit;
      next_sdo_en_n = 1'b0;
    end
    else if (four_wire_serial_sel)
      next_sdo_en_n = ~serial_read_active;
  end

  // ----------------------------------------
  // Loop controls and data path
  // ----------------------------------------
  always @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      chan_a_data_out <= 16'h0000;
      chan_b_data_out <= 16'h0000;
      serial_data_out <= 1'b0;
      serial_data_out_en_n <= 1'b1;
      delay_filter_zero <= 1'b0;
      delay_line_ctrl <= `CLOCFG_DELAY_MID;
      delay_loop_acquire <= 1'b0;
      delay_loop_locked <= 1'b0;
      delay_trim <= 4'h0;
      delay_clk_invert <= 1'b0;
      delay_bias <= 3'h0;
      delay_bias_forbidden <= 1'b0;
      feedback_mult <= 6'h01;
      ref_div <= 4'h1;
      div_code_invalid <= 1'b0;
      loop_filter_clamp <= 1'b0;
      osc_halving <= 1'b0;
      osc_gain <= 2'h0;
      osc_range <= 4'h0;
      offset_loaded <= 1'b0;
    end
    else
    begin
      serial_data_out <= next_sdo;
      serial_data_out_en_n <= next_sdo_en_n;
      delay_filter_zero <= restart;
      if (restart)
        delay_line_ctrl <= `CLOCFG_DELAY_MID;
      delay_loop_acquire <= ~restart;
      delay_loop_locked <= delay_loop_lock_raw & ~restart;
      delay_trim <= delay_tuning[`CLOCFG_TRIM_MSB:`CLOCFG_TRIM_LSB];
      delay_clk_invert <= delay_tuning[`CLOCFG_INVCLK_BIT];
      delay_bias <= delay_tuning[`CLOCFG_BIAS_MSB:`CLOCFG_BIAS_LSB];
      delay_bias_forbidden <= (delay_tuning[`CLOCFG_BIAS_MSB:`CLOCFG_BIAS_LSB]
        == `CLOCFG_BIAS_FORBIDDEN);
      feedback_mult <= mult_decode(mult_div[`CLOCFG_MULT_MSB:`CLOCFG_MULT_LSB]);
      ref_div <= div_decode(mult_div[`CLOCFG_REFDIV_MSB:`CLOCFG_REFDIV_LSB]);
      div_code_invalid <= (mult_decode(mult_div[`CLOCFG_MULT_MSB:`CLOCFG_MULT_LSB]) == 6'h00)
        | (div_decode(mult_div[`CLOCFG_REFDIV_MSB:`CLOCFG_REFDIV_LSB]) == 4'h0);
      loop_filter_clamp <= loop_tuning[`CLOCFG_CLAMP_BIT];
      osc_halving <= loop_tuning[`CLOCFG_HALVING_BIT];
      osc_gain <= loop_tuning[`CLOCFG_GAIN_MSB:`CLOCFG_GAIN_LSB];
      osc_range <= loop_tuning[`CLOCFG_RANGE_MSB:`CLOCFG_RANGE_LSB];
      offset_loaded <= load_pulse;
      if (offset_enable)
      begin
        chan_a_data_out <= add_offset(chan_a_data_in, work_a);
        chan_b_data_out <= add_offset(chan_b_data_in, work_b);
      end
      else
      begin
        chan_a_data_out <= chan_a_data_in;
        chan_b_data_out <= chan_b_data_in;
      end
    end
  end

endmodule // clocfg_regs_top

// File: testbench/clocfg_regs_sva.sv
// Concurrent checks on the ports of the clock and offset configuration bank
`timescale 1ns/1ps
module clocfg_regs_sva (
  input wire sys_clk,
  input wire reset_n,
  input wire reg_wr,
  input wire reg_rd,
  input wire [4:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire reg_rvalid,
  input wire offset_enable,
  input wire [15:0] chan_a_data_in,
  input wire [15:0] chan_a_data_out,
  input wire delay_filter_zero,
  input wire [7:0] delay_line_ctrl,
  input wire delay_loop_acquire,
  input wire delay_loop_locked,
  input wire [5:0] feedback_mult,
  input wire [3:0] ref_div,
  input wire div_code_invalid,
  input wire loop_filter_clamp,
  input wire osc_halving,
  input wire offset_loaded
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  // Helpers keep $past on plain signals
  wire strobe_set = reg_wr && reg_addr == 5'h0C && reg_wdata[5];
  wire restart_wr = reg_wr && reg_addr == 5'h08;
  wire tune_wr = reg_wr && reg_addr == 5'h0B;
  wire wd2 = reg_wdata[2];
  wire wd6 = reg_wdata[6];
  wire wd7 = reg_wdata[7];
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  chk_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe not answered");
  chk_unmapped_zero: assert property (reg_rd && !(reg_addr inside {[5'h08:5'h0F]})
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  chk_restart_hold: assert property (delay_filter_zero |-> delay_line_ctrl == 8'h80)
    else $error("delay line not centred in restart");
  chk_lock_gated: assert property (delay_filter_zero |-> !delay_loop_locked)
    else $error("lock shown during restart");
  chk_restart_write: assert property (restart_wr |-> ##2
    delay_filter_zero == $past(wd2, 2) && delay_loop_acquire != $past(wd2, 2))
    else $error("restart write not applied");
  chk_decode_flag: assert property (div_code_invalid ==
    (feedback_mult == 6'h00 || ref_div == 4'h0)) else $error("invalid flag wrong");
  chk_div_eight: assert property (reg_wr && reg_addr == 5'h09 && reg_wdata[2:0] == 3'h7
    |-> ##2 ref_div == 4'h8) else $error("divider code 111 not 8");
  chk_load_cause: assert property (offset_loaded |-> $past(strobe_set, 3))
    else $error("load without strobe rise");
  chk_single_load: assert property (offset_loaded |=> !offset_loaded)
    else $error("load repeated while strobe held");
  chk_offset_bypass: assert property ($past(reset_n) && !$past(offset_enable)
    |-> chan_a_data_out == $past(chan_a_data_in)) else $error("bypass data wrong");
  chk_clamp_write: assert property (tune_wr |-> ##2 loop_filter_clamp == $past(wd7, 2)
    && osc_halving == $past(wd6, 2)) else $error("loop tuning write not applied");
  cov_load: cover property (offset_loaded);
  cov_restart: cover property ($fell(delay_filter_zero));
  cov_unmapped: cover property (reg_rd && reg_addr == 5'h1F);
endmodule // clocfg_regs_sva

// File: testbench/clocfg_host_model.sv
// Host controller model issuing register strobes to the bank
`timescale 1ns/1ps
module clocfg_host_model (
  input wire sys_clk,
  output reg reg_wr,
  output reg reg_rd,
  output reg [4:0] reg_addr,
  output reg [7:0] reg_wdata
);
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  // After an access the written data or the read address is left inverted so a stale bus never looks valid
  initial
  begin
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    reg_wr = 1'h1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge sys_clk);
    #1;
    reg_wr = 1'h0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge sys_clk);
    #1;
    reg_rd = 1'h1;
    reg_addr = a;
    @(posedge sys_clk);
    #1;
    reg_rd = 1'h0;
    reg_addr = ~a;
  endtask
endmodule // clocfg_host_model

// File: testbench/tb_clock_loop_offset_config_regs.sv
// Self-checking bench for the clock loop and offset configuration bank
`timescale 1ns/1ps
module tb_clock_loop_offset_config_regs;
  // ----------------------------------------
  // Signals and helpers
  // ----------------------------------------
  reg sys_clk = 1'h0, reset_n = 1'h0, four_wire_serial_sel = 1'h0, offset_enable = 1'h0;
  reg serial_read_bit = 1'h0, serial_read_active = 1'h0, phase_loop_lock = 1'h0;
  reg delay_loop_lock_raw = 1'h0, pattern_err = 1'h0, buffer_err = 1'h0;
  reg self_check_fail_flag = 1'h0;
  reg [15:0] chan_a_data_in = 16'h0000, chan_b_data_in = 16'h0000;
  wire reg_wr, reg_rd, reg_rvalid, serial_data_out, serial_data_out_en_n, delay_filter_zero;
  wire delay_loop_acquire, delay_loop_locked, delay_clk_invert, delay_bias_forbidden;
  wire div_code_invalid, loop_filter_clamp, osc_halving, offset_loaded;
  wire [4:0] reg_addr;
  wire [7:0] reg_wdata, reg_rdata, delay_line_ctrl;
  wire [15:0] chan_a_data_out, chan_b_data_out;
  wire [3:0] delay_trim, ref_div, osc_range;
  wire [2:0] delay_bias;
  wire [5:0] feedback_mult;
  wire [1:0] osc_gain;
  int i, num_errors = 0, n_checks = 0, cyc = 0;
  logic [7:0] exp_q[$];
  logic [7:0] d, e;
  logic [12:0] oa, ob;
  logic [5:0] st;
  logic [2:0] s;
  logic [4:0] mc [0:6] = '{5'h00, 5'h01, 5'h03, 5'h07, 5'h0F, 5'h1F, 5'h02};
  logic [5:0] mv [0:6] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h00};
  logic [2:0] nc [0:4] = '{3'h0, 3'h1, 3'h3, 3'h7, 3'h2};
  logic [3:0] nv [0:4] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0};
  clocfg_regs_top i_dut (.*);
  clocfg_host_model i_host (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  always #2 sys_clk = ~sys_clk;
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] sn);
    n_checks++;
    if (sn !== ex)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, sn);
    end
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] ex);
    exp_q.push_back(ex);
    i_host.rd(a);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic stage(input logic [12:0] a, input logic [12:0] b, input logic sb);
    i_host.wr(5'h0C, {2'h0, sb, a[12:8]});
    i_host.wr(5'h0D, a[7:0]);
    i_host.wr(5'h0E, {3'h0, b[12:8]});
    i_host.wr(5'h0F, b[7:0]);
  endtask
  task automatic chk_ofs;
    chk("chan_a_data_out", chan_a_data_in + {{3{oa[12]}}, oa}, chan_a_data_out);
    chk("chan_b_data_out", chan_b_data_in + {{3{ob[12]}}, ob}, chan_b_data_out);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Read results taken off the queue in issue order; also the hang guard
  always @(negedge sys_clk)
  begin
    if (reg_rvalid === 1'h1)
      chk("reg_rdata", exp_q.size() > 0 ? exp_q.pop_front() : 8'hEE, reg_rdata);
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      summarize();
    end
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(66));
    chan_a_data_in = 16'($urandom);
    chan_b_data_in = 16'($urandom);
    repeat (8) @(posedge sys_clk);
    #1;
    reset_n = 1'h1;
    offset_enable = 1'h1;
    chk("delay_line_ctrl", 16'h0080, delay_line_ctrl);
    chk("feedback_mult", 16'h0001, feedback_mult);
    chk("ref_div", 16'h0001, ref_div);
    chk("serial_data_out_en_n", 16'h0001, serial_data_out_en_n);
    oa = 13'h0000;
    ob = 13'h0000;
    tick(2);
    chk_ofs();
    for (i = 8; i < 16; i++)
      rd(i[4:0], 8'h00);
    $display("test reset_values done");
    d = 8'($urandom);
    i_host.wr(5'h09, d);
    i_host.wr(5'h03, ~d);
    rd(5'h09, d);
    rd(5'h03, 8'h00);
    rd(5'h1F, 8'h00);
    delay_loop_lock_raw = 1'h1;
    i_host.wr(5'h08, 8'h04);
    tick(2);
    chk("delay_filter_zero", 16'h0001, delay_filter_zero);
    chk("delay_line_ctrl", 16'h0080, delay_line_ctrl);
    chk("delay_loop_locked", 16'h0000, delay_loop_locked);
    chk("delay_loop_acquire", 16'h0000, delay_loop_acquire);
    rd(5'h08, 8'h04);
    i_host.wr(5'h08, 8'h00);
    tick(2);
    chk("delay_loop_acquire", 16'h0001, delay_loop_acquire);
    chk("delay_loop_locked", 16'h0001, delay_loop_locked);
    $display("test restart done");
    for (i = 0; i < 7; i++)
    begin
      i_host.wr(5'h09, {mc[i], nc[i % 5]});
      tick(2);
      chk("feedback_mult", mv[i], feedback_mult);
      chk("ref_div", nv[i % 5], ref_div);
      chk("div_code_invalid", mv[i] == 6'h00 || nv[i % 5] == 4'h0, div_code_invalid);
    end
    for (i = 0; i < 4; i++)
    begin
      d = 8'($urandom);
      e = 8'($urandom);
      d[2:0] = i[0] ? 3'h3 : (i[1] ? 3'h5 : 3'h0);
      i_host.wr(5'h0A, d);
      i_host.wr(5'h0B, e);
      tick(2);
      chk("delay_trim", d[7:4], delay_trim);
      chk("delay_clk_invert", d[3], delay_clk_invert);
      chk("delay_bias", d[2:0], delay_bias);
      chk("delay_bias_forbidden", d[2:0] == 3'h4, delay_bias_forbidden);
      chk("loop_filter_clamp", e[7], loop_filter_clamp);
      chk("osc_halving", e[6], osc_halving);
      chk("osc_gain", e[5:4], osc_gain);
      chk("osc_range", e[3:0], osc_range);
      rd(5'h0B, e);
      i_host.wr(5'h0B, {1'h0, e[6:0]});
      i_host.wr(5'h08, 8'h04);
      i_host.wr(5'h08, 8'h00);
    end
    $display("test loop_settings done");
    for (i = 0; i < 2; i++)
    begin
      i_host.wr(5'h0C, 8'h00);
      oa = i == 1 ? 13'h1000 : 13'($urandom);
      ob = 13'($urandom);
      stage(oa, ob, 1'h0);
      i_host.wr(5'h0C, {3'h1, oa[12:8]});
      tick(2);
      chk("offset_loaded", 16'h0001, offset_loaded);
      chk_ofs();
      stage(~oa, ~ob, 1'h1);
      tick(3);
      chk_ofs();
      rd(5'h0D, ~oa[7:0]);
      rd(5'h0F, ~ob[7:0]);
    end
    offset_enable = 1'h0;
    tick(2);
    chk("chan_a_data_out", chan_a_data_in, chan_a_data_out);
    $display("test offsets done");
    for (i = 0; i < 16; i++)
    begin
      {serial_read_active, serial_read_bit, phase_loop_lock, delay_loop_lock_raw} = 4'($urandom);
      {pattern_err, buffer_err, self_check_fail_flag} = 3'($urandom);
      four_wire_serial_sel = i[3];
      s = i[2:0];
      st = {self_check_fail_flag, buffer_err, pattern_err, delay_loop_lock_raw,
        phase_loop_lock, serial_read_bit};
      i_host.wr(5'h0E, {s, 5'h00});
      tick(2);
      if (s >= 3'h1 && s <= 3'h5)
      begin
        chk("serial_data_out", st[s], serial_data_out);
        chk("serial_data_out_en_n", 16'h0000, serial_data_out_en_n);
      end
      else
      begin
        chk("serial_data_out_en_n", four_wire_serial_sel ? !serial_read_active : 1'h1,
          serial_data_out_en_n);
        if (four_wire_serial_sel)
          chk("serial_data_out", serial_read_bit, serial_data_out);
      end
    end
    $display("test serial_out done");
    tick(2);
    chk("read_queue", 16'h0000, exp_q.size());
    summarize();
  end
endmodule // tb_clock_loop_offset_config_regs
bind clocfg_regs_top clocfg_regs_sva i_sva (.*);
